// ==== pkg/twl_pkg.sv ====
// Package for the three-wire latch loader: widths, select codes, monitor codes and carriers.
package twl_pkg;

	// ----------------------------------------
	// Word layout
	// ----------------------------------------
	localparam int WORD_W    = 24;
	localparam int SEL_W     = 2;
	localparam int PAYLOAD_W = WORD_W - SEL_W;
	localparam int SEL_LSB   = 0;
	localparam int PAY_LSB   = 2;

	// ----------------------------------------
	// Destination select codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		TWL_DEST_CONTROL = 2'b00,
		TWL_DEST_RCOUNT  = 2'b01,
		TWL_DEST_NCOUNT  = 2'b10,
		TWL_DEST_TEST    = 2'b11
	} twl_dest_t;

	// ----------------------------------------
	// Power-down and monitor fields of the control latch payload
	// ----------------------------------------
	localparam int PD_LSB  = 18;
	localparam int PD_W    = 2;
	localparam int MON_LSB = 3;
	localparam int MON_W   = 3;
	localparam logic [1:0] PD_RUN = 2'h0;

	typedef enum logic [2:0] {
		TWL_MON_LOW    = 3'b000,
		TWL_MON_LOCK   = 3'b001,
		TWL_MON_RFDIV  = 3'b010,
		TWL_MON_REFDIV = 3'b100
	} twl_mon_t;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [23:0] WORD_RST    = 24'h00_0000;
	localparam logic [21:0] PAYLOAD_RST = 22'h00_0000;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic sclk;
		logic sdata;
		logic load_strobe;
	} twl_serial_t;

	typedef struct packed {
		logic [21:0] control;
		logic [21:0] rcount;
		logic [21:0] ncount;
		logic [21:0] test;
	} twl_latches_t;

endpackage : twl_pkg

// ==== src/twl_loader.sv ====
// Three-wire serial loader: shift register, four latches, power-down and monitor select.
`timescale 1ns/1ps
`default_nettype none

module twl_loader
	import twl_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire twl_pkg::twl_serial_t  serial_in,
	input  wire logic                  chip_enable,
	input  wire logic                  pump_up_req,
	input  wire logic                  pump_dn_req,
	input  wire logic                  lock_detect,
	input  wire logic                  rf_divided,
	input  wire logic                  ref_divided,
	output logic                       monitor_output,
	output logic                       pump_output_up,
	output logic                       pump_output_dn,
	output logic                       pump_output_oe,
	output logic                       powered_up,
	output twl_pkg::twl_latches_t      latches
);
	import twl_pkg::*;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// True when the power-down field of a control payload asks for normal running.
	function automatic logic pd_allows_run
	(
		input logic [PAYLOAD_W-1:0] ctrl
	);
		return (ctrl[PD_LSB +: PD_W] == PD_RUN);
	endfunction : pd_allows_run

	// Picks the source that the monitor code names; unknown codes give a quiet low.
	function automatic logic mon_pick
	(
		input twl_mon_t   sel,
		input logic [2:0] src
	);
		case (sel)
			TWL_MON_LOCK:   return src[2];
			TWL_MON_RFDIV:  return src[1];
			TWL_MON_REFDIV: return src[0];
			default:        return 1'h0;
		endcase
	endfunction : mon_pick

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	twl_serial_t ser_meta_ff;
	twl_serial_t ser_sync_ff;
	twl_serial_t ser_prev_ff;
	logic [1:0]  ce_sync_ff;
	logic [2:0]  mon_meta_ff;
	logic [2:0]  mon_sync_ff;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ser_meta_ff <= '0;
			ser_sync_ff <= '0;
			ser_prev_ff <= '0;
			ce_sync_ff  <= 2'h0;
			mon_meta_ff <= 3'h0;
			mon_sync_ff <= 3'h0;
		end
		else
		begin
			ser_meta_ff <= serial_in;
			ser_sync_ff <= ser_meta_ff;
			ser_prev_ff <= ser_sync_ff;
			ce_sync_ff  <= {ce_sync_ff[0], chip_enable};
			mon_meta_ff <= {lock_detect, rf_divided, ref_divided};
			mon_sync_ff <= mon_meta_ff;
		end
	end

	logic sclk_rise;
	logic strobe_rise;
	logic ce_level;

	assign sclk_rise   = ser_sync_ff.sclk & ~ser_prev_ff.sclk;
	assign strobe_rise = ser_sync_ff.load_strobe & ~ser_prev_ff.load_strobe;
	assign ce_level    = ce_sync_ff[1];

	// ----------------------------------------
	// Shift register
	// ----------------------------------------
	logic [WORD_W-1:0] shift_ff;

	// Each sampled serial clock rise moves the word one place towards the top.
	always_ff @(posedge clk)
	begin
		if (rst)
			shift_ff <= WORD_RST;
		else if (sclk_rise)
			shift_ff <= {shift_ff[WORD_W-2:0], ser_sync_ff.sdata};
	end

	// ----------------------------------------
	// Latch transfer
	// ----------------------------------------
	twl_dest_t            dest_sel;
	logic [PAYLOAD_W-1:0] payload;
	twl_latches_t         latches_ff;

	assign dest_sel = twl_dest_t'(shift_ff[SEL_LSB +: SEL_W]);
	assign payload  = shift_ff[PAY_LSB +: PAYLOAD_W];

	// Latches move only on a strobe rising edge, so shifting never disturbs them.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			latches_ff.control <= PAYLOAD_RST;
			latches_ff.rcount  <= PAYLOAD_RST;
			latches_ff.ncount  <= PAYLOAD_RST;
			latches_ff.test    <= PAYLOAD_RST;
		end
		else if (strobe_rise)
		begin
			case (dest_sel)
				TWL_DEST_CONTROL: latches_ff.control <= payload;
				TWL_DEST_RCOUNT:  latches_ff.rcount  <= payload;
				TWL_DEST_NCOUNT:  latches_ff.ncount  <= payload;
				TWL_DEST_TEST:    latches_ff.test    <= payload;
				default:          latches_ff.test    <= latches_ff.test;
			endcase
		end
	end

	assign latches = latches_ff;

	// ----------------------------------------
	// Power-down and charge pump
	// ----------------------------------------
	logic powered_up_ff;
	logic pump_oe_ff;
	logic pump_up_ff;
	logic pump_dn_ff;

	// Low chip enable overrides the programmed bits.
	always_ff @(posedge clk)
	begin
		if (rst)
			powered_up_ff <= 1'h0;
		else
			powered_up_ff <= ce_level && pd_allows_run(latches_ff.control);
	end

	// The pump pin is driven only while the device runs; otherwise it floats.
	always_ff @(posedge clk)
	begin
		if (rst)
			pump_oe_ff <= 1'h0;
		else
			pump_oe_ff <= ce_level && pd_allows_run(latches_ff.control);
	end

	// Drive requests are gated by chip enable only, so a pump floated by the power-down bits can still carry a pulse.
	always_ff @(posedge clk)
	begin
		if (rst)
			pump_up_ff <= 1'h0;
		else
			pump_up_ff <= pump_up_req & ce_level;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pump_dn_ff <= 1'h0;
		else
			pump_dn_ff <= pump_dn_req & ce_level;
	end

	assign powered_up     = powered_up_ff;
	assign pump_output_oe = pump_oe_ff;
	assign pump_output_up = pump_up_ff;
	assign pump_output_dn = pump_dn_ff;

	// ----------------------------------------
	// Monitor output
	// ----------------------------------------
	twl_mon_t mon_sel;
	logic     monitor_ff;

	assign mon_sel = twl_mon_t'(latches_ff.control[MON_LSB +: MON_W]);

	// The sources are already synchronised, so the pick adds a single register only.
	always_ff @(posedge clk)
	begin
		if (rst)
			monitor_ff <= 1'h0;
		else
			monitor_ff <= mon_pick(mon_sel, mon_sync_ff);
	end

	assign monitor_output = monitor_ff;

endmodule : twl_loader

`default_nettype wire

// ==== sim/twl_loader_asserts.sv ====
// Port checker for the three-wire latch loader.
`timescale 1ns/1ps
`default_nettype none
module twl_loader_asserts
	import twl_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 rst,
	input wire twl_pkg::twl_serial_t serial_in,
	input wire logic                 chip_enable,
	input wire logic                 monitor_output,
	input wire logic                 pump_output_up,
	input wire logic                 pump_output_dn,
	input wire logic                 pump_output_oe,
	input wire logic                 powered_up,
	input wire twl_pkg::twl_latches_t latches
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	wire logic [1:0] pd = latches.control[PD_LSB +: PD_W];
	wire logic [2:0] mon = latches.control[MON_LSB +: MON_W];
	chk_oe_off: assert property (!chip_enable [*4] |-> !pump_output_oe)
		else $error("pump driven with chip enable low");
	chk_pump_gate: assert property (!chip_enable [*4] |-> !pump_output_up && !pump_output_dn)
		else $error("pump drive active with chip enable low");
	chk_ce_down: assert property (!chip_enable [*4] |-> !powered_up)
		else $error("powered with chip enable low");
	chk_pd_bits: assert property (powered_up |-> $past(pd) == PD_RUN)
		else $error("powered although power-down bits set");
	chk_pd_run: assert property ((chip_enable && pd == PD_RUN) [*4] |-> powered_up)
		else $error("not powered with enable and run bits");
	chk_latch_hold: assert property ($changed(latches) |-> $past(serial_in.load_strobe, 2)
		|| $past(serial_in.load_strobe, 3) || $past(serial_in.load_strobe, 4))
		else $error("latch changed without load strobe");
	chk_one_latch: assert property ($onehot0({$changed(latches.control), $changed(latches.rcount),
		$changed(latches.ncount), $changed(latches.test)}))
		else $error("more than one latch changed");
	chk_mon_off: assert property (!(mon inside {3'h1, 3'h2, 3'h4}) [*2] |-> !monitor_output)
		else $error("monitor active with no source selected");
	cover property ($changed(latches.ncount));
	cover property ($rose(powered_up));
	cover property ($rose(monitor_output));
endmodule : twl_loader_asserts
bind twl_loader twl_loader_asserts u_chk (.*);
`default_nettype wire

// ==== sim/twl_host.sv ====
// Controller model that drives the serial programming pins.
`timescale 1ns/1ps
`default_nettype none
module twl_host
	import twl_pkg::*;
(
	input  wire logic                clk,
	output var twl_pkg::twl_serial_t ser
);
	initial ser = '0;
	task automatic send(input logic [23:0] w, input bit ld);
		for (int i = 23; i >= 0; i--)
		begin
			@(negedge clk);
			ser.sdata = w[i];
			repeat (2) @(negedge clk);
			ser.sclk = 1'b1;
			repeat (2) @(negedge clk);
			ser.sclk = 1'b0;
		end
		ser.sdata = ~ser.sdata;
		repeat (2) @(negedge clk);
		ser.load_strobe = ld;
		repeat (2) @(negedge clk);
		ser.load_strobe = 1'b0;
		repeat (8) @(negedge clk);
	endtask : send
endmodule : twl_host
`default_nettype wire

// ==== sim/test_three_wire_latch_loader.sv ====
// Self-checking bench for the three-wire latch loader.
`timescale 1ns/1ps
`default_nettype none
module test_three_wire_latch_loader;
	import twl_pkg::*;
	logic clk = 0, rst = 1, chip_enable = 0, pump_up_req = 1, pump_dn_req = 1;
	logic lock_detect = 0, rf_divided = 0, ref_divided = 0;
	logic monitor_output, pump_output_up, pump_output_dn, pump_output_oe, powered_up;
	twl_serial_t serial_in;
	twl_latches_t latches;
	int err_count = 0, comparisons = 0, seed = 32'h0000_94b6, e;
	logic [21:0] ex[4] = '{default: 22'h00_0000};
	logic [1:0] order[3] = '{TWL_DEST_RCOUNT, TWL_DEST_CONTROL, TWL_DEST_NCOUNT};
	logic [2:0] mons[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
	twl_loader dut (
		.clk(clk), .rst(rst), .serial_in(serial_in), .chip_enable(chip_enable),
		.pump_up_req(pump_up_req), .pump_dn_req(pump_dn_req), .lock_detect(lock_detect),
		.rf_divided(rf_divided), .ref_divided(ref_divided), .monitor_output(monitor_output),
		.pump_output_up(pump_output_up), .pump_output_dn(pump_output_dn),
		.pump_output_oe(pump_output_oe), .powered_up(powered_up), .latches(latches)
	);
	twl_host host (.clk(clk), .ser(serial_in));
	initial forever #20 clk = ~clk;
	task automatic check(input string n, input logic [87:0] s, input logic [87:0] e);
		comparisons++;
		if (s !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask : check
	task automatic put(input logic [1:0] sel, input logic [1:0] pd, input logic [2:0] m, input bit ld);
		logic [21:0] p;
		p = 22'($random(seed));
		if (sel == TWL_DEST_CONTROL)
			p = {p[21:20], pd, p[17:6], m, p[2:0]};
		host.send({p, sel}, ld);
		if (ld)
			ex[sel] = p;
		check("latches", latches, {ex[0], ex[1], ex[2], ex[3]});
	endtask : put
	task automatic stop_test;
		$display("compared %0d, mismatched %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	initial
	begin
		#1_000_000;
		err_count++;
		stop_test;
	end
	initial
	begin
		repeat (16) @(negedge clk);
		rst = 0;
		chip_enable = 1;
		foreach (order[s])
			put(order[s], 2'h0, 3'h1, 1);
		put(2'h2, 2'h0, 3'h0, 0);
		check("power", {powered_up, pump_output_oe, pump_output_up, pump_output_dn}, 4'hf);
		$display("latch test done");
		foreach (mons[k])
		begin
			put(TWL_DEST_CONTROL, 2'h0, mons[k], 1);
			repeat (3)
			begin
				{lock_detect, rf_divided, ref_divided} = 3'($random(seed));
				repeat (6) @(negedge clk);
				e = k == 0 ? lock_detect : k == 1 ? rf_divided : k == 2 ? ref_divided : 0;
				check("monitor", monitor_output, e[0]);
			end
		end
		$display("monitor test done");
		put(TWL_DEST_CONTROL, 2'h1, 3'h0, 1);
		check("pd bits", powered_up, 1'b0);
		put(TWL_DEST_CONTROL, 2'h0, 3'h0, 1);
		chip_enable = 0;
		repeat (6) @(negedge clk);
		check("ce low", {powered_up, pump_output_oe, pump_output_up, pump_output_dn}, 4'h0);
		chip_enable = 1;
		repeat (6) @(negedge clk);
		check("ce high", powered_up, 1'b1);
		$display("power test done");
		stop_test;
	end
endmodule : test_three_wire_latch_loader
`default_nettype wire
